//--- design/sfp_defs.svh
// constants shared by both ends of the serial flash pin link
// assumes a 20 MHz system clock on both ends
`ifndef SFP_DEFS_SVH
`define SFP_DEFS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define SFP_CMD_WRITE_SR 8'h01
`define SFP_CMD_READ_SR 8'h05
`define SFP_CMD_DUAL_READ_SR 8'h3B
`define SFP_CMD_QUAD_OUTPUT_FAST_READ 8'h6B
`define SFP_CMD_QUAD_IO_FAST_READ 8'hEB

// ----------------------------------------------------------------
// status register
// ----------------------------------------------------------------
`define SFP_SR_FREEZE_BIT 7
`define SFP_SR_RESET 7'h00
`define SFP_BYTE_BITS 4'h8

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SFP_CLK_PERIOD_NS 50
`define SFP_SCLK_PERIOD_NS 800
`define SFP_SCLK_HALF_CYCLES (`SFP_SCLK_PERIOD_NS / (2 * `SFP_CLK_PERIOD_NS))
`define SFP_WRITE_BUSY_NS 2000
`define SFP_WRITE_BUSY_CYCLES \
	((`SFP_WRITE_BUSY_NS + `SFP_CLK_PERIOD_NS - 1) / `SFP_CLK_PERIOD_NS)

`endif

//--- design/sfp_pkg.sv
// types and lane decoding shared by host and device
// assumes sfp_defs.svh is on the include path
`include "sfp_defs.svh"
`default_nettype none

package sfp_pkg;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		sfp_extended_io_protocol = 2'h0,
		sfp_dual_io_protocol = 2'h1,
		sfp_quad_io_protocol = 2'h2
	} sfp_proto_t;

	typedef enum logic [1:0] {
		sfp_share_none = 2'h0,
		sfp_share_pause = 2'h1,
		sfp_share_reset = 2'h2
	} sfp_share_t;

	typedef enum logic [1:0] {
		sfp_w1 = 2'h0,
		sfp_w2 = 2'h1,
		sfp_w4 = 2'h3
	} sfp_width_t;

	typedef enum logic [1:0] {
		sfp_idle = 2'h0,
		sfp_cmd = 2'h1,
		sfp_data = 2'h3,
		sfp_done = 2'h2
	} sfp_state_t;

	// ----------------------------------------------------------------
	// decoding
	// ----------------------------------------------------------------
	function automatic logic [3:0] sfp_step(sfp_width_t w);
		sfp_step = 4'h1;
		if (w == sfp_w2)
			sfp_step = 4'h2;
		if (w == sfp_w4)
			sfp_step = 4'h4;
	endfunction

	function automatic sfp_width_t sfp_cmd_width(sfp_proto_t p);
		sfp_cmd_width = sfp_w1;
		if (p == sfp_dual_io_protocol)
			sfp_cmd_width = sfp_w2;
		if (p == sfp_quad_io_protocol)
			sfp_cmd_width = sfp_w4;
	endfunction

	function automatic logic sfp_cmd_known(logic [7:0] c);
		sfp_cmd_known = (c == `SFP_CMD_WRITE_SR) || (c == `SFP_CMD_READ_SR)
			|| (c == `SFP_CMD_DUAL_READ_SR)
			|| (c == `SFP_CMD_QUAD_OUTPUT_FAST_READ)
			|| (c == `SFP_CMD_QUAD_IO_FAST_READ);
	endfunction

	// every known command but the status write hands data back
	function automatic logic sfp_cmd_reads(logic [7:0] c);
		sfp_cmd_reads = sfp_cmd_known(c) && (c != `SFP_CMD_WRITE_SR);
	endfunction

	function automatic sfp_width_t sfp_data_width(sfp_proto_t p,
		logic [7:0] c);
		sfp_data_width = sfp_cmd_width(p);
		if (p == sfp_extended_io_protocol && c == `SFP_CMD_DUAL_READ_SR)
			sfp_data_width = sfp_w2;
		if (p == sfp_extended_io_protocol
			&& (c == `SFP_CMD_QUAD_OUTPUT_FAST_READ
			|| c == `SFP_CMD_QUAD_IO_FAST_READ))
			sfp_data_width = sfp_w4;
	endfunction

	// single line: host drives line zero, device drives line one
	function automatic logic [3:0] sfp_lane_mask(sfp_width_t w,
		logic dev_drives);
		sfp_lane_mask = 4'hF;
		if (w == sfp_w1)
			sfp_lane_mask = dev_drives ? 4'h2 : 4'h1;
		if (w == sfp_w2)
			sfp_lane_mask = 4'h3;
	endfunction

	function automatic logic [3:0] sfp_lanes_out(sfp_width_t w,
		logic dev_drives, logic [7:0] b);
		sfp_lanes_out = b[7:4];
		if (w == sfp_w1)
			sfp_lanes_out = dev_drives ? {2'h0, b[7], 1'b0} : {3'h0, b[7]};
		if (w == sfp_w2)
			sfp_lanes_out = {2'h0, b[7:6]};
	endfunction

	function automatic logic [3:0] sfp_lanes_in(sfp_width_t w,
		logic dev_drives, logic [3:0] io);
		sfp_lanes_in = io;
		if (w == sfp_w1)
			sfp_lanes_in = {3'h0, dev_drives ? io[1] : io[0]};
		if (w == sfp_w2)
			sfp_lanes_in = {2'h0, io[1:0]};
	endfunction

endpackage

`default_nettype wire

//--- design/sfp_link_if.sv
// link between host controller and flash pin-function device
// level of each data line is resolved here from both enables
`default_nettype none

interface sfp_link_if;
	logic select_b;
	logic sclk;
	logic [3:0] host_io_out;
	logic [3:0] host_io_oe_b;
	logic [3:0] dev_io_out;
	logic [3:0] dev_io_oe_b;
	logic [3:0] serial_io;

	// undriven line reads high; contention resolves low
	assign serial_io = (host_io_oe_b | host_io_out)
		& (dev_io_oe_b | dev_io_out);

	modport host (
		output select_b,
		output sclk,
		output host_io_out,
		output host_io_oe_b,
		input serial_io
	);

	modport device (
		input select_b,
		input sclk,
		input serial_io,
		output dev_io_out,
		output dev_io_oe_b
	);
endinterface

`default_nettype wire

//--- design/sfp_device.sv
// flash end of the link: lane use, pause, shared reset, status freeze
// assumes a host that makes the link clock and keeps line levels defined
//
// Contract
// R1: shared reset ignored in quad protocol
// R2: pause suspends, tri-states, ignores inputs
// R3: config bit 4 disables pause
// R4: shared pause off in quad or double-rate
// R5: freeze bit with protect low blocks writes
// R6: protect pin is data line two in quad
// R7: host drives the protect pin; the host releases it from quad-width read data until after deselect
// R8: single line: line zero in, one out
// R9: dual: lines one and zero bidirectional
// R10: quad: all four lines bidirectional
// R11: everything moves over the data lines
// R12: deselect gives standby, internal write continues
// R13: single rate rise in, fall out
// R14: reset low resets, tri-states, bit 4 disables
// R15: falling select needed before first command
// R16: pause release resumes at same bit
// R17: host holds shared line three high
`default_nettype none

module sfp_device (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// link
	sfp_link_if.device link,
	// configuration
	input wire sfp_pkg::sfp_proto_t proto,
	input wire logic dtr_enable,
	input wire sfp_pkg::sfp_share_t line_three_share,
	input wire logic nv_cfg_func_dis,
	input wire logic v_cfg_func_dis,
	// status
	output logic [7:0] status_value,
	output logic hold_active,
	output logic reset_active,
	output logic write_refused,
	output logic selected
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic sclk_q;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync_a <= 6'h1F;
			sync_b <= 6'h1F;
		end
		else
		begin
			sync_a <= {link.sclk, link.select_b, link.serial_io};
			sync_b <= sync_a;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			sclk_q <= 1'b0;
		else
			sclk_q <= sync_b[5];
	end

	logic sel_b_s;
	logic [3:0] io_s;
	logic serial_io_line_two;
	logic serial_io_line_three;
	logic rise;
	logic fall;

	assign sel_b_s = sync_b[4];
	assign io_s = sync_b[3:0];
	assign serial_io_line_two = io_s[2];
	assign serial_io_line_three = io_s[3];
	assign rise = sync_b[5] & ~sclk_q;
	assign fall = ~sync_b[5] & sclk_q;

	// ----------------------------------------------------------------
	// shared line three functions
	// ----------------------------------------------------------------
	sfp_pkg::sfp_state_t state;
	sfp_pkg::sfp_width_t width;
	logic [7:0] sh;
	logic [3:0] cnt;
	logic [7:0] code;
	logic func_dis;
	logic line_three_data;
	logic pause_now;
	logic reset_now;

	// line three carrying quad data never acts as pause or reset
	assign line_three_data = (proto == sfp_pkg::sfp_quad_io_protocol)
		|| (state == sfp_pkg::sfp_data && width == sfp_pkg::sfp_w4);
	// R3: bit 4 of either register
	assign func_dis = nv_cfg_func_dis | v_cfg_func_dis;
	// R4: pause gating
	assign pause_now = line_three_share == sfp_pkg::sfp_share_pause
		&& !serial_io_line_three && !func_dis && !line_three_data
		&& !dtr_enable;
	// R1: reset gating
	assign reset_now = line_three_share == sfp_pkg::sfp_share_reset
		&& !serial_io_line_three && !func_dis && !line_three_data;

	// ----------------------------------------------------------------
	// command and data sequencing
	// ----------------------------------------------------------------
	logic seen_high;
	logic reads;
	logic last;
	logic sample_edge;
	logic drive_edge;
	logic [3:0] next_cnt;
	logic [7:0] next_sh;
	logic [7:0] status_byte;

	assign reads = sfp_pkg::sfp_cmd_reads(code);
	assign next_cnt = cnt + sfp_pkg::sfp_step(width);
	assign last = next_cnt == `SFP_BYTE_BITS;
	// R11: all fields enter through the data lanes
	assign next_sh = (sh << sfp_pkg::sfp_step(width))
		| {4'h0, sfp_pkg::sfp_lanes_in(width, 1'b0, io_s)};
	// R13: rise in, fall out; double rate uses both edges for data
	assign sample_edge = state == sfp_pkg::sfp_data && !reads
		&& (rise || (dtr_enable && fall));
	assign drive_edge = state == sfp_pkg::sfp_data && reads
		&& (fall || (dtr_enable && rise)) && !pause_now;

	// R15: start only after select seen high
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			seen_high <= 1'b0;
		else if (sel_b_s)
			seen_high <= 1'b1;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= sfp_pkg::sfp_idle;
			width <= sfp_pkg::sfp_w1;
			sh <= 8'h00;
			cnt <= 4'h0;
			code <= 8'h00;
		end
		// R14: reset; R12: deselect
		else if (reset_now || sel_b_s)
		begin
			state <= sfp_pkg::sfp_idle;
			cnt <= 4'h0;
		end
		// R16: pause freezes all sequencing state
		else if (!pause_now)
		begin
			unique case (state)
			sfp_pkg::sfp_idle:
				if (seen_high)
				begin
					state <= sfp_pkg::sfp_cmd;
					width <= sfp_pkg::sfp_cmd_width(proto);
					cnt <= 4'h0;
				end
			sfp_pkg::sfp_cmd:
				if (rise)
				begin
					sh <= next_sh;
					cnt <= last ? 4'h0 : next_cnt;
					if (last)
					begin
						code <= next_sh;
						width <= sfp_pkg::sfp_data_width(proto, next_sh);
						state <= sfp_pkg::sfp_cmd_known(next_sh)
							? sfp_pkg::sfp_data : sfp_pkg::sfp_done;
						if (sfp_pkg::sfp_cmd_reads(next_sh))
							sh <= status_byte;
					end
				end
			sfp_pkg::sfp_data:
				if (sample_edge)
				begin
					sh <= next_sh;
					cnt <= next_cnt;
					if (last)
						state <= sfp_pkg::sfp_done;
				end
				else if (drive_edge)
				begin
					sh <= sh << sfp_pkg::sfp_step(width);
					cnt <= last ? 4'h0 : next_cnt;
					// reads repeat the status byte until deselect
					if (last)
						sh <= status_byte;
				end
			sfp_pkg::sfp_done:
				cnt <= 4'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// status register, freeze and internal write
	// ----------------------------------------------------------------
	localparam int BUSY_CYCLES = `SFP_WRITE_BUSY_CYCLES;
	logic [6:0] sr;
	logic [7:0] busy_cnt;
	logic wr_take;
	logic frozen;

	assign status_byte = {sr, busy_cnt != 8'h00};
	assign wr_take = sample_edge && last && !pause_now && !sel_b_s
		&& !reset_now;
	// R5, R6: protect role only when line two not data
	assign frozen = sr[`SFP_SR_FREEZE_BIT - 1] && !serial_io_line_two
		&& proto != sfp_pkg::sfp_quad_io_protocol;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sr <= `SFP_SR_RESET;
			busy_cnt <= 8'h00;
			write_refused <= 1'b0;
		end
		else
		begin
			write_refused <= 1'b0;
			// R12: internal write runs on regardless of select
			if (busy_cnt != 8'h00)
				busy_cnt <= busy_cnt - 8'h01;
			// R14: reset aborts an internal write
			if (reset_now)
				busy_cnt <= 8'h00;
			else if (wr_take)
			begin
				// R5: frozen status refuses the write
				if (frozen)
					write_refused <= 1'b1;
				else
				begin
					sr <= next_sh[7:1];
					busy_cnt <= 8'(BUSY_CYCLES);
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// output lanes
	// ----------------------------------------------------------------
	logic drv_on;
	logic next_drv_on;
	logic leave;

	assign leave = reset_now || sel_b_s || state != sfp_pkg::sfp_data
		|| !reads;
	assign next_drv_on = leave ? 1'b0 : (drive_edge ? 1'b1 : drv_on);

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			drv_on <= 1'b0;
			link.dev_io_out <= 4'h0;
			link.dev_io_oe_b <= 4'hF;
		end
		else
		begin
			drv_on <= next_drv_on;
			// R8: line one; R9: lines one and zero; R10: all four
			if (drive_edge)
				link.dev_io_out <= sfp_pkg::sfp_lanes_out(width, 1'b1, sh);
			// R2: pause tri-states, drive comes back on release
			link.dev_io_oe_b <= (next_drv_on && !pause_now)
				? ~sfp_pkg::sfp_lane_mask(width, 1'b1) : 4'hF;
		end
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			status_value <= 8'h00;
			hold_active <= 1'b0;
			reset_active <= 1'b0;
			selected <= 1'b0;
		end
		else
		begin
			status_value <= status_byte;
			hold_active <= pause_now;
			reset_active <= reset_now;
			selected <= state != sfp_pkg::sfp_idle;
		end
	end

endmodule // sfp_device

`default_nettype wire

//--- design/sfp_host.sv
// host end of the link: makes the link clock and runs one command
// assumes the device end decodes the same lane use per protocol
`default_nettype none

module sfp_host (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// link
	sfp_link_if.host link,
	// request
	input wire logic start,
	input wire logic [7:0] cmd_code,
	input wire logic [7:0] wr_byte,
	input wire sfp_pkg::sfp_proto_t proto,
	input wire logic dtr_enable,
	// line two and three levels
	input wire logic wp_level,
	input wire logic pause_req,
	input wire logic reset_req,
	// answer
	output logic [7:0] rd_byte,
	output logic xfer_done,
	output logic xfer_busy
);

	// ----------------------------------------------------------------
	// input synchroniser and clock divider
	// ----------------------------------------------------------------
	localparam logic [3:0] HALF = 4'(`SFP_SCLK_HALF_CYCLES);
	logic [3:0] io_a;
	logic [3:0] io_s;
	logic [3:0] div_cnt;
	sfp_pkg::sfp_state_t state;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			io_a <= 4'hF;
			io_s <= 4'hF;
		end
		else
		begin
			io_a <= link.serial_io;
			io_s <= io_a;
		end
	end

	logic edge_now;
	logic rising_now;
	logic falling_now;
	logic mid_now;

	logic [2:0] resume_cnt;
	logic clk_hold;

	// device needs its synchroniser time to drive again after release
	assign clk_hold = pause_req || resume_cnt != 3'h0;
	// R16: link clock stands still while pause is asked for
	assign edge_now = div_cnt == HALF - 4'h1 && !clk_hold;
	assign mid_now = div_cnt == (HALF >> 1) - 4'h1 && !clk_hold;
	assign rising_now = edge_now && !link.sclk;
	assign falling_now = edge_now && link.sclk;

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			div_cnt <= 4'h0;
		else if (state == sfp_pkg::sfp_idle || edge_now)
			div_cnt <= 4'h0;
		else if (!clk_hold)
			div_cnt <= div_cnt + 4'h1;
	end

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
			resume_cnt <= 3'h0;
		else if (pause_req)
			resume_cnt <= 3'h6;
		else if (resume_cnt != 3'h0)
			resume_cnt <= resume_cnt - 3'h1;
	end

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	sfp_pkg::sfp_width_t width;
	sfp_pkg::sfp_width_t drv_w;
	logic [7:0] sh;
	logic [3:0] cnt;
	logic [3:0] lane_q;
	logic reading;
	logic drv;
	logic aux_on;
	logic skip_fall;
	logic [1:0] idle_age;
	logic [3:0] next_cnt;
	logic last;
	logic data_edge;
	logic update;

	assign next_cnt = cnt + sfp_pkg::sfp_step(width);
	assign last = next_cnt == `SFP_BYTE_BITS;
	// R13: single rate data on rise, double rate on both edges
	assign data_edge = state == sfp_pkg::sfp_data
		&& (rising_now || (dtr_enable && falling_now && !skip_fall));
	assign update = mid_now && (!link.sclk
		|| (dtr_enable && state == sfp_pkg::sfp_data));

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= sfp_pkg::sfp_idle;
			width <= sfp_pkg::sfp_w1;
			drv_w <= sfp_pkg::sfp_w1;
			sh <= 8'h00;
			cnt <= 4'h0;
			lane_q <= 4'h0;
			reading <= 1'b0;
			drv <= 1'b0;
			aux_on <= 1'b1;
			skip_fall <= 1'b0;
			idle_age <= 2'h3;
			rd_byte <= 8'h00;
			xfer_done <= 1'b0;
			xfer_busy <= 1'b0;
			link.select_b <= 1'b1;
			link.sclk <= 1'b0;
		end
		else
		begin
			xfer_done <= 1'b0;
			if (edge_now && (state != sfp_pkg::sfp_done || link.sclk))
				link.sclk <= ~link.sclk;
			unique case (state)
			sfp_pkg::sfp_idle:
			begin
				// R7: lines two and three wait until the device lets go
				if (idle_age != 2'h3)
					idle_age <= idle_age + 2'h1;
				aux_on <= aux_on | idle_age[1];
				// R15: select falls at the start of every command
				if (start)
				begin
					aux_on <= 1'b1;
					state <= sfp_pkg::sfp_cmd;
					xfer_busy <= 1'b1;
					link.select_b <= 1'b0;
					width <= sfp_pkg::sfp_cmd_width(proto);
					drv_w <= sfp_pkg::sfp_cmd_width(proto);
					lane_q <= sfp_pkg::sfp_lanes_out(
						sfp_pkg::sfp_cmd_width(proto), 1'b0, cmd_code);
					sh <= cmd_code << sfp_pkg::sfp_step(
						sfp_pkg::sfp_cmd_width(proto));
					cnt <= 4'h0;
					drv <= 1'b1;
					reading <= sfp_pkg::sfp_cmd_reads(cmd_code);
				end
			end
			sfp_pkg::sfp_cmd:
			begin
				// first bit already stands from the start
				if (update && cnt != 4'h0)
				begin
					lane_q <= sfp_pkg::sfp_lanes_out(width, 1'b0, sh);
					sh <= sh << sfp_pkg::sfp_step(width);
				end
				if (rising_now)
				begin
					cnt <= last ? 4'h0 : next_cnt;
					if (last)
					begin
						state <= sfp_pkg::sfp_data;
						width <= sfp_pkg::sfp_data_width(proto, cmd_code);
						sh <= wr_byte;
						skip_fall <= 1'b1;
					end
				end
			end
			sfp_pkg::sfp_data:
			begin
				if (falling_now)
					skip_fall <= 1'b0;
				// lanes turn round on the falling edge, before the device drives
				if (falling_now && reading)
				begin
					drv <= 1'b0;
					if (width == sfp_pkg::sfp_w4)
						aux_on <= 1'b0;
				end
				if (update && !reading)
				begin
					drv_w <= width;
					lane_q <= sfp_pkg::sfp_lanes_out(width, 1'b0, sh);
					sh <= sh << sfp_pkg::sfp_step(width);
				end
				if (data_edge && (reading ? !skip_fall || rising_now : 1'b1))
				begin
					cnt <= next_cnt;
					if (reading)
						sh <= (sh << sfp_pkg::sfp_step(width)) | {4'h0,
							sfp_pkg::sfp_lanes_in(width, 1'b1, io_s)};
					if (last)
						state <= sfp_pkg::sfp_done;
				end
			end
			sfp_pkg::sfp_done:
				if (edge_now && !link.sclk)
				begin
					state <= sfp_pkg::sfp_idle;
					link.select_b <= 1'b1;
					drv <= 1'b0;
					idle_age <= 2'h0;
					xfer_busy <= 1'b0;
					xfer_done <= 1'b1;
					rd_byte <= reading ? sh : 8'h00;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// line drive
	// ----------------------------------------------------------------
	logic [3:0] dmask;
	logic [3:0] amask;
	logic [3:0] aux_val;

	// R8, R9, R10: lanes per width; R6: line two as data in quad
	assign dmask = drv ? sfp_pkg::sfp_lane_mask(drv_w, 1'b0) : 4'h0;
	assign amask = aux_on ? 4'hC & ~dmask : 4'h0;
	// R7: protect level; R17: line three high unless asked low
	assign aux_val = {~(pause_req | reset_req), wp_level, 2'h0};

	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			link.host_io_out <= 4'hC;
			link.host_io_oe_b <= 4'h3;
		end
		else
		begin
			link.host_io_out <= (lane_q & dmask) | (aux_val & ~dmask);
			link.host_io_oe_b <= ~(dmask | amask);
		end
	end

endmodule // sfp_host

`default_nettype wire

//--- verif/sfp_link_checker.sv
// link checker: timing and line ownership across both ends
// assumes the bench instantiates it beside the link interface
`default_nettype none

module sfp_link_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// link
	input wire logic select_b,
	input wire logic sclk,
	input wire logic [3:0] host_io_out,
	input wire logic [3:0] host_io_oe_b,
	input wire logic [3:0] dev_io_out,
	input wire logic [3:0] dev_io_oe_b,
	input wire logic [3:0] serial_io
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	// device sees select through a synchroniser, so allow a few cycles
	desel_release_a:
	assert property ($rose(select_b) |-> ##[1:5] dev_io_oe_b == 4'hF)
		else $error("device lanes not released after deselect");

	idle_tristate_a:
	assert property (select_b [*5] |-> dev_io_oe_b == 4'hF)
		else $error("device drives while deselected");

	no_contention_a:
	assert property (!select_b |-> (host_io_oe_b | dev_io_oe_b) == 4'hF)
		else $error("both ends drive one line");

	idle_lines_driven_a:
	assert property (select_b [*5] |-> host_io_oe_b[3:2] == 2'h0)
		else $error("host leaves line two or three floating");

	idle_clock_low_a:
	assert property (select_b |-> !sclk)
		else $error("link clock runs outside a frame");

	select_lead_a:
	assert property ($fell(select_b) |-> !sclk [*2])
		else $error("clock edge too close to select fall");

	clock_high_half_a:
	assert property ($rose(sclk) |-> sclk [*8])
		else $error("link clock high phase too short");

	clock_low_half_a:
	assert property ($fell(sclk) |-> !sclk [*8])
		else $error("link clock low phase too short");

	cover property ($fell(select_b));
	cover property (dev_io_oe_b == 4'h0);
	cover property (dev_io_oe_b == 4'hD);
endmodule // sfp_link_checker

`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for host and device ends on one link
// assumes both design ends and the link interface are compiled
`default_nettype none

module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic clock = 1'b0;
	logic rst_b = 1'b0;
	logic start = 1'b0;
	logic [7:0] cmd_code = 8'h00;
	logic [7:0] wr_byte = 8'h00;
	sfp_pkg::sfp_proto_t proto = sfp_pkg::sfp_extended_io_protocol;
	sfp_pkg::sfp_share_t share = sfp_pkg::sfp_share_none;
	logic dtr_enable = 1'b0;
	logic nv_dis = 1'b0;
	logic v_dis = 1'b0;
	logic wp_level = 1'b1;
	logic pause_req = 1'b0;
	logic reset_req = 1'b0;
	logic [7:0] rd_byte;
	logic [7:0] status_value;
	logic xfer_done;
	logic hold_active;
	logic reset_active;
	logic write_refused;
	logic selected;
	logic xfer_busy;
	logic refused_seen = 1'b0;
	int bad_count = 0;
	int checked = 0;
	logic [7:0] cmds [6] = '{8'h05, 8'h3B, 8'h6B, 8'hEB, 8'h05, 8'h05};
	logic [1:0] protos [6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2};
	// bits: nv disable, v disable, double rate, quad
	logic [3:0] cfgs [5] = '{4'h0, 4'h8, 4'h4, 4'h2, 4'h1};

	sfp_link_if link ();

	sfp_host sfp_host_i (.clock(clock), .rst_b(rst_b), .link(link),
		.start(start), .cmd_code(cmd_code), .wr_byte(wr_byte),
		.proto(proto), .dtr_enable(dtr_enable), .wp_level(wp_level),
		.pause_req(pause_req), .reset_req(reset_req), .rd_byte(rd_byte),
		.xfer_done(xfer_done), .xfer_busy(xfer_busy));

	sfp_device sfp_device_i (.clock(clock), .rst_b(rst_b), .link(link),
		.proto(proto), .dtr_enable(dtr_enable), .line_three_share(share),
		.nv_cfg_func_dis(nv_dis), .v_cfg_func_dis(v_dis),
		.status_value(status_value), .hold_active(hold_active),
		.reset_active(reset_active), .write_refused(write_refused),
		.selected(selected));

	sfp_link_checker sfp_link_checker_i (.clock(clock), .rst_b(rst_b),
		.select_b(link.select_b), .sclk(link.sclk),
		.host_io_out(link.host_io_out), .host_io_oe_b(link.host_io_oe_b),
		.dev_io_out(link.dev_io_out), .dev_io_oe_b(link.dev_io_oe_b),
		.serial_io(link.serial_io));

	always #25 clock = ~clock;

	// refusal is a one-cycle pulse, so latch it
	always @(posedge clock)
		if (write_refused === 1'b1)
			refused_seen <= 1'b1;

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic xfer(input logic [7:0] c, input logic [7:0] w,
		input logic [7:0] exp, input bit rd);
		int n;
		n = 0;
		@(negedge clock);
		cmd_code = c;
		wr_byte = w;
		start = 1'b1;
		@(negedge clock);
		start = 1'b0;
		while (xfer_done !== 1'b1 && n < 3000)
		begin
			@(negedge clock);
			n++;
		end
		if (n >= 3000)
			check("xfer_done", 8'h00, 8'h01);
		if (rd)
			check("rd_byte", rd_byte, exp);
	endtask

	// write then let the internal busy time run out
	task automatic write_sr(input logic [7:0] w);
		xfer(8'h01, w, 8'h00, 1'b0);
		repeat (60) @(negedge clock);
	endtask

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial
	begin
		repeat (5) @(negedge clock);
		rst_b = 1'b1;
		xfer(8'h05, 8'h00, 8'h00, 1'b1);
		xfer(8'h01, 8'hA4, 8'h00, 1'b0);
		check("busy", {7'h00, status_value[0]}, 8'h01);
		repeat (60) @(negedge clock);
		check("status", status_value, 8'hA4);
		for (int i = 0; i < 6; i++)
		begin
			proto = sfp_pkg::sfp_proto_t'(protos[i]);
			xfer(cmds[i], 8'h00, 8'hA4, 1'b1);
		end
		proto = sfp_pkg::sfp_extended_io_protocol;
		$display("test lanes done");

		write_sr(8'h84);
		wp_level = 1'b0;
		refused_seen = 1'b0;
		write_sr(8'h10);
		check("refused", {7'h00, refused_seen}, 8'h01);
		check("frozen", status_value, 8'h84);
		wp_level = 1'b1;
		write_sr(8'h10);
		check("unfrozen", status_value, 8'h10);
		$display("test freeze done");

		share = sfp_pkg::sfp_share_pause;
		fork
			xfer(8'h05, 8'h00, 8'h10, 1'b1);
			begin
				repeat (196) @(negedge clock);
				pause_req = 1'b1;
				repeat (12) @(negedge clock);
				check("hold", {7'h00, hold_active}, 8'h01);
				check("selected", {7'h00, selected}, 8'h01);
				check("busy", {7'h00, xfer_busy}, 8'h01);
				check("paused oe", {4'h0, link.dev_io_oe_b}, 8'h0F);
				pause_req = 1'b0;
			end
		join
		$display("test pause done");

		for (int k = 0; k < 2; k++)
		begin
			share = k ? sfp_pkg::sfp_share_reset : sfp_pkg::sfp_share_pause;
			for (int i = 0; i < 5; i++)
			begin
				{nv_dis, v_dis, dtr_enable} = cfgs[i][3:1];
				proto = sfp_pkg::sfp_proto_t'({cfgs[i][0], 1'b0});
				pause_req = (k == 0);
				reset_req = (k == 1);
				repeat (8) @(negedge clock);
				if (k == 0)
					check("hold", {7'h00, hold_active}, {7'h00, cfgs[i] == 4'h0});
				else
					check("reset", {7'h00, reset_active},
						{7'h00, cfgs[i][3:2] == 2'h0 && !cfgs[i][0]});
				pause_req = 1'b0;
				reset_req = 1'b0;
				repeat (8) @(negedge clock);
				check("released", {6'h00, hold_active, reset_active}, 8'h00);
			end
		end
		{nv_dis, v_dis, dtr_enable} = 3'h0;
		proto = sfp_pkg::sfp_extended_io_protocol;
		xfer(8'h05, 8'h00, 8'h10, 1'b1);
		dtr_enable = 1'b1;
		xfer(8'h05, 8'h00, 8'h10, 1'b1);
		dtr_enable = 1'b0;
		$display("test line three done");
		complete_run();
	end

	// whole run needs about 3500 cycles
	initial
	begin
		repeat (60000) @(posedge clock);
		bad_count++;
		complete_run();
	end
endmodule // testbench

`default_nettype wire
